// ---- hdl/fcs_fan_ctrl.sv ----
// Condenser fan speed controller: regulation, relays and output drive
`timescale 1ns/1ns
module fcs_fan_ctrl #(
  parameter int unsigned TENTH_CYC = fcs_pkg::TENTH_CYC,
  parameter int unsigned HALF50_CYC = fcs_pkg::HALF50_CYC,
  parameter int unsigned HALF60_CYC = fcs_pkg::HALF60_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Process inputs
  input wire logic [15:0] cond_val_a_i,
  input wire logic [15:0] cond_val_b_i,
  input wire logic comp_run_a_i,
  input wire logic comp_run_b_i,
  input wire logic defrost_a_i,
  input wire logic defrost_b_i,
  input wire logic heat_mode_i,
  input wire logic zero_cross_i,
  input wire logic alarm_i,
  // Fan configuration
  input wire logic [1:0] fan_output_mode_sel_i,
  input wire logic [7:0] fan_pickup_interval_i,
  input wire logic fan_follows_compressor_sel_i,
  input wire logic [6:0] cool_min_speed_i,
  input wire logic [6:0] cool_silent_max_speed_i,
  input wire logic [15:0] cool_min_speed_setpoint_i,
  input wire logic [15:0] cool_prop_band_i,
  input wire logic [15:0] fan_cutoff_diff_i,
  input wire logic [15:0] fan_cutoff_hyst_i,
  input wire logic [7:0] fan_cutoff_bypass_time_i,
  input wire logic [6:0] cool_high_speed_step_i,
  input wire logic [15:0] cool_high_speed_point_i,
  input wire logic [6:0] heat_min_speed_i,
  input wire logic [6:0] heat_silent_max_speed_i,
  input wire logic [15:0] heat_min_speed_setpoint_i,
  input wire logic [15:0] heat_prop_band_i,
  input wire logic combined_condenser_sel_i,
  input wire logic [15:0] defrost_fan_thr_i,
  input wire logic [15:0] defrost_fan_hyst_i,
  input wire logic [6:0] fan_step2_level_i,
  input wire logic [6:0] fan_step3_level_i,
  // Output configuration
  input wire logic analog_out1_type_i,
  input wire logic analog_out2_type_i,
  input wire logic mains_freq_sel_i,
  input wire logic [3:0][4:0] relay_func_i,
  input wire logic [3:0] relay_pol_i,
  input wire logic alarm_relay_pol_i,
  // Fan drive outputs
  output logic [7:0] analog_fan_out_a_o,
  output logic [7:0] analog_fan_out_b_o,
  output logic triac_fan_out_a_o,
  output logic triac_fan_out_b_o,
  output logic [6:0] fan_level_a_o,
  output logic [6:0] fan_level_b_o,
  // Relay outputs, index 0 is relay_out_2
  output logic [3:0] relay_out_o,
  output logic alarm_relay_o
);
  fcs_pkg::fcs_top_t s_reg, s_next;
  fcs_tick_if tk ();
  logic [15:0] vmax, vmin;
  logic [1:0][15:0] val_w;
  logic [1:0] comp_w, defr_w, cut_w, rest_w, dhi_w, dlo_w;
  logic [1:0][6:0] dem_w;
  logic [1:0] atype_w;
  logic [1:0] triac_w;
  logic [3:0] act_w;
  localparam logic [6:0] PCT_ZERO_F = fcs_pkg::PCT_ZERO;

  // Linear interpolation; band 0 never reaches here
  function automatic logic [6:0] ramp(input logic [6:0] lo, input logic [6:0] hi,
                                      input logic [15:0] d, input logic [15:0] band);
    logic [22:0] p;
    p = 23'h000000;
    if (hi <= lo) begin
      ramp = lo;
    end else begin
      p = 23'(hi - lo) * 23'(d);
      ramp = lo + 7'(p / 23'(band));
    end
  endfunction

  function automatic logic [6:0] prop_lvl(input logic [15:0] v);
    prop_lvl = PCT_ZERO_F;
    if (!heat_mode_i) begin
      if (v < cool_min_speed_setpoint_i) begin
        prop_lvl = cool_min_speed_i;
      end else if (v >= cool_high_speed_point_i) begin
        prop_lvl = cool_high_speed_step_i;
      end else if (v - cool_min_speed_setpoint_i >= cool_prop_band_i) begin
        prop_lvl = cool_silent_max_speed_i;
      end else begin
        prop_lvl = ramp(cool_min_speed_i, cool_silent_max_speed_i,
                        v - cool_min_speed_setpoint_i, cool_prop_band_i);
      end
    end else begin
      if (v > heat_min_speed_setpoint_i) begin
        prop_lvl = heat_min_speed_i;
      end else if (heat_min_speed_setpoint_i - v >= heat_prop_band_i) begin
        prop_lvl = heat_silent_max_speed_i;
      end else begin
        prop_lvl = ramp(heat_min_speed_i, heat_silent_max_speed_i,
                        heat_min_speed_setpoint_i - v, heat_prop_band_i);
      end
    end
  endfunction

  function automatic logic relay_act(input logic [4:0] code, input fcs_pkg::fcs_top_t st);
    case (code)
      fcs_pkg::RF_FAN_C1: relay_act = st.ch[0].lvl != fcs_pkg::PCT_ZERO;
      fcs_pkg::RF_FAN_C2: relay_act = st.ch[1].lvl != fcs_pkg::PCT_ZERO;
      fcs_pkg::RF_S2_C1: relay_act = st.ch[0].lvl != fcs_pkg::PCT_ZERO && st.ch[0].lvl >= fan_step2_level_i;
      fcs_pkg::RF_S3_C1: relay_act = st.ch[0].lvl != fcs_pkg::PCT_ZERO && st.ch[0].lvl >= fan_step3_level_i;
      fcs_pkg::RF_S2_C2: relay_act = st.ch[1].lvl != fcs_pkg::PCT_ZERO && st.ch[1].lvl >= fan_step2_level_i;
      fcs_pkg::RF_S3_C2: relay_act = st.ch[1].lvl != fcs_pkg::PCT_ZERO && st.ch[1].lvl >= fan_step3_level_i;
      default: relay_act = 1'b0;
    endcase
  endfunction

  assign vmax = (cond_val_a_i > cond_val_b_i) ? cond_val_a_i : cond_val_b_i;
  assign vmin = (cond_val_a_i > cond_val_b_i) ? cond_val_b_i : cond_val_a_i;
  assign atype_w = {analog_out2_type_i, analog_out1_type_i};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      logic [15:0] own;
      logic cmp, dfr;
      logic [6:0] p;
      assign own = (g == 0) ? cond_val_a_i : cond_val_b_i;
      assign cmp = (g == 0) ? comp_run_a_i : comp_run_b_i;
      assign dfr = (g == 0) ? defrost_a_i : defrost_b_i;
      assign val_w[g] = combined_condenser_sel_i ? (heat_mode_i ? vmin : vmax) : own;
      assign comp_w[g] = combined_condenser_sel_i ? (comp_run_a_i | comp_run_b_i) : cmp;
      assign defr_w[g] = combined_condenser_sel_i ? (defrost_a_i | defrost_b_i) : dfr;
      assign p = prop_lvl(val_w[g]);
      assign cut_w[g] = heat_mode_i ?
        ({1'b0, val_w[g]} > {1'b0, heat_min_speed_setpoint_i} + {1'b0, fan_cutoff_diff_i}) :
        ({1'b0, val_w[g]} + {1'b0, fan_cutoff_diff_i} < {1'b0, cool_min_speed_setpoint_i});
      assign rest_w[g] = heat_mode_i ?
        ({1'b0, val_w[g]} + {1'b0, fan_cutoff_hyst_i} <=
         {1'b0, heat_min_speed_setpoint_i} + {1'b0, fan_cutoff_diff_i}) :
        ({1'b0, val_w[g]} + {1'b0, fan_cutoff_diff_i} >=
         {1'b0, cool_min_speed_setpoint_i} + {1'b0, fan_cutoff_hyst_i});
      assign dhi_w[g] = val_w[g] > defrost_fan_thr_i;
      assign dlo_w[g] = {1'b0, val_w[g]} + {1'b0, defrost_fan_hyst_i} < {1'b0, defrost_fan_thr_i};
      // One continuous driver per channel slice of the demand word
      assign dem_w[g] =
        (fan_output_mode_sel_i == fcs_pkg::FMODE_COMP) ? (comp_w[g] ? fcs_pkg::PCT_FULL : fcs_pkg::PCT_ZERO) :
        defr_w[g] ? (s_reg.ch[g].defr_on ? fcs_pkg::PCT_FULL : fcs_pkg::PCT_ZERO) :
        (!fan_follows_compressor_sel_i && !comp_w[g]) ? fcs_pkg::PCT_ZERO :
        (fan_output_mode_sel_i == fcs_pkg::FMODE_ONOFF) ?
          ((p != fcs_pkg::PCT_ZERO) ? fcs_pkg::PCT_FULL : fcs_pkg::PCT_ZERO) :
        p;
      fcs_phase_cut #(
        .HALF50(HALF50_CYC),
        .HALF60(HALF60_CYC)
      ) u_pc (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .en_i(!atype_w[g]),
        .mains60_i(mains_freq_sel_i),
        .zc_i(zero_cross_i),
        .level_i(s_reg.ch[g].lvl),
        .fire_o(triac_w[g])
      );
    end
    for (g = 0; g < fcs_pkg::NRELAY; g++) begin : g_rly
      assign act_w[g] = relay_act(relay_func_i[g], s_reg);
    end
  endgenerate

  fcs_tick #(
    .TENTH(TENTH_CYC)
  ) u_tick (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .tk(tk.src)
  );

  always_comb begin
    fcs_pkg::fcs_ch_t ch;
    logic [14:0] ma;
    ch = '0;
    ma = 15'h0000;
    s_next = s_reg;
    for (int c = 0; c < 2; c++) begin
      ch = s_reg.ch[c];
      if (!defr_w[c]) begin
        ch.defr_on = 1'b0;
      end else if (dhi_w[c]) begin
        ch.defr_on = 1'b1;
      end else if (dlo_w[c]) begin
        ch.defr_on = 1'b0;
      end
      if (tk.sec && ch.byp != 8'h00 && (ch.st == fcs_pkg::FCS_PICK || ch.st == fcs_pkg::FCS_RUN)) begin
        ch.byp = ch.byp - 8'h01;
      end
      case (ch.st)
        fcs_pkg::FCS_OFF: begin
          if (dem_w[c] != fcs_pkg::PCT_ZERO) begin
            ch.st = (fan_pickup_interval_i == 8'h00) ? fcs_pkg::FCS_RUN : fcs_pkg::FCS_PICK;
            ch.pick = fan_pickup_interval_i;
            ch.byp = fan_cutoff_bypass_time_i;
          end
        end
        fcs_pkg::FCS_PICK: begin
          if (dem_w[c] == fcs_pkg::PCT_ZERO) begin
            ch.st = fcs_pkg::FCS_OFF;
          end else if (ch.pick == 8'h00) begin
            ch.st = fcs_pkg::FCS_RUN;
          end else if (tk.tenth) begin
            ch.pick = ch.pick - 8'h01;
          end
        end
        fcs_pkg::FCS_RUN: begin
          if (dem_w[c] == fcs_pkg::PCT_ZERO) begin
            ch.st = fcs_pkg::FCS_OFF;
          // cut only in regulation, bypass expired
          end else if (cut_w[c] && ch.byp == 8'h00 && !defr_w[c] &&
                       fan_output_mode_sel_i != fcs_pkg::FMODE_COMP) begin
            ch.st = fcs_pkg::FCS_CUT;
          end
        end
        fcs_pkg::FCS_CUT: begin
          // Restart passes through pick-up again
          if (dem_w[c] == fcs_pkg::PCT_ZERO || rest_w[c]) begin
            ch.st = fcs_pkg::FCS_OFF;
          end
        end
        default: ch.st = fcs_pkg::FCS_OFF;
      endcase
      case (ch.st)
        fcs_pkg::FCS_PICK: ch.lvl = fcs_pkg::PCT_FULL;
        fcs_pkg::FCS_RUN: ch.lvl = dem_w[c];
        default: ch.lvl = fcs_pkg::PCT_ZERO;
      endcase
      s_next.ch[c] = ch;
      // 4-20mA scaling in tenths of mA
      ma = 15'(s_reg.ch[c].lvl) * 15'(fcs_pkg::MA_SPAN) / 15'(fcs_pkg::PCT_FULL);
      s_next.ana[c] = atype_w[c] ? fcs_pkg::MA_BASE + ma[7:0] : 8'h00;
    end
    s_next.rly = act_w ^ relay_pol_i;
    s_next.alr = alarm_i ^ alarm_relay_pol_i;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg <= '0;
      s_reg.ch[0].st <= fcs_pkg::FCS_OFF;
      s_reg.ch[1].st <= fcs_pkg::FCS_OFF;
    end else begin
      s_reg <= s_next;
    end
  end

  assign analog_fan_out_a_o = s_reg.ana[0];
  assign analog_fan_out_b_o = s_reg.ana[1];
  assign triac_fan_out_a_o = triac_w[0];
  assign triac_fan_out_b_o = triac_w[1];
  assign fan_level_a_o = s_reg.ch[0].lvl;
  assign fan_level_b_o = s_reg.ch[1].lvl;
  assign relay_out_o = s_reg.rly;
  assign alarm_relay_o = s_reg.alr;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_pick_full;
    s_reg.ch[0].st == fcs_pkg::FCS_PICK |-> fan_level_a_o == fcs_pkg::PCT_FULL;
  endproperty
  a_pick_full: assert property (p_pick_full) else $error("pick-up not at full speed");
  property p_run_dem;
    s_reg.ch[0].st == fcs_pkg::FCS_RUN |-> fan_level_a_o == $past(dem_w[0]);
  endproperty
  a_run_dem: assert property (p_run_dem) else $error("running level differs from demand");
  property p_onoff;
    $past(fan_output_mode_sel_i) == fcs_pkg::FMODE_ONOFF |->
      fan_level_a_o == fcs_pkg::PCT_ZERO || fan_level_a_o == fcs_pkg::PCT_FULL;
  endproperty
  a_onoff: assert property (p_onoff) else $error("on-off mode gave partial level");
  property p_comp_mode;
    fan_output_mode_sel_i == fcs_pkg::FMODE_COMP && !comp_w[0] |=> fan_level_a_o == fcs_pkg::PCT_ZERO;
  endproperty
  a_comp_mode: assert property (p_comp_mode) else $error("fan on with no compressor running");
  property p_follow;
    fan_output_mode_sel_i != fcs_pkg::FMODE_COMP && !fan_follows_compressor_sel_i && !comp_w[1] && !defr_w[1]
      |=> fan_level_b_o == fcs_pkg::PCT_ZERO;
  endproperty
  a_follow: assert property (p_follow) else $error("fan on with compressor off");
  property p_bypass;
    $rose(s_reg.ch[0].st == fcs_pkg::FCS_CUT) |-> s_reg.ch[0].byp == 8'h00;
  endproperty
  a_bypass: assert property (p_bypass) else $error("cut-off inside bypass time");
  property p_ma;
    $past(analog_out1_type_i) |-> analog_fan_out_a_o >= fcs_pkg::MA_BASE &&
      analog_fan_out_a_o <= fcs_pkg::MA_BASE + fcs_pkg::MA_SPAN;
  endproperty
  a_ma: assert property (p_ma) else $error("current output out of 4-20mA");
  property p_relay;
    $past(rstn_i) |-> relay_out_o == $past(act_w ^ relay_pol_i);
  endproperty
  a_relay: assert property (p_relay) else $error("relay polarity wrong");
  property p_combined;
    combined_condenser_sel_i && !heat_mode_i |-> val_w[0] == vmax && val_w[1] == vmax;
  endproperty
  a_combined: assert property (p_combined) else $error("combined condenser not on higher reading");
  c_pick_run: cover property (s_reg.ch[0].st == fcs_pkg::FCS_PICK ##1 s_reg.ch[0].st == fcs_pkg::FCS_RUN);
  c_cut: cover property (s_reg.ch[0].st == fcs_pkg::FCS_CUT);
  c_defrost: cover property (defr_w[0] && s_reg.ch[0].defr_on);
endmodule

// ---- hdl/fcs_phase_cut.sv ----
// Mains-locked triac firing for one phase-cut fan output
`timescale 1ns/1ns
module fcs_phase_cut #(
  parameter int unsigned HALF50 = fcs_pkg::HALF50_CYC,
  parameter int unsigned HALF60 = fcs_pkg::HALF60_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Control
  input wire logic en_i,
  input wire logic mains60_i,
  input wire logic zc_i,
  input wire logic [6:0] level_i,
  // Gate pulse
  output logic fire_o
);
  typedef struct packed {
    logic zc_d;
    logic armed;
    logic [23:0] cnt;
    logic [23:0] dly;
    logic [9:0] pw;
    logic fire;
  } fcs_pc_t;
  fcs_pc_t s_reg, s_next;
  logic [23:0] half;
  logic [31:0] prod;
  logic zc_edge;

  assign half = mains60_i ? 24'(HALF60) : 24'(HALF50);
  assign prod = 32'(half) * 32'(fcs_pkg::PCT_FULL - level_i);
  assign zc_edge = zc_i && !s_reg.zc_d;

  always_comb begin
    s_next = s_reg;
    s_next.zc_d = zc_i;
    if (zc_edge) begin
      s_next.cnt = 24'h000000;
      s_next.dly = 24'(prod / 32'(fcs_pkg::PCT_FULL));
      s_next.armed = en_i && (level_i != fcs_pkg::PCT_ZERO);
    end else if (s_reg.cnt != 24'hFFFFFF) begin
      s_next.cnt = s_reg.cnt + 24'h000001;
    end
    if (s_reg.pw != 10'h000) begin
      s_next.pw = s_reg.pw - 10'h001;
    end
    if (!zc_edge && s_reg.armed && s_reg.cnt == s_reg.dly) begin
      s_next.pw = fcs_pkg::FIRE_CYC;
      s_next.armed = 1'b0;
    end
    // Output off at once when the channel leaves phase-cut duty
    if (!en_i) begin
      s_next.armed = 1'b0;
      s_next.pw = 10'h000;
    end
    s_next.fire = s_next.pw != 10'h000;
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign fire_o = s_reg.fire;

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_fire_at_delay;
    $rose(fire_o) |-> $past(s_reg.armed) && $past(s_reg.cnt) == $past(s_reg.dly);
  endproperty
  a_fire_at_delay: assert property (p_fire_at_delay) else $error("triac fired off its delay");
  property p_delay_in_half;
    zc_edge |=> s_reg.dly <= (mains60_i ? HALF60 : HALF50);
  endproperty
  a_delay_in_half: assert property (p_delay_in_half) else $error("firing delay beyond half cycle");
  c_fire: cover property ($rose(fire_o));
endmodule

// ---- hdl/fcs_pkg.sv ----
// Shared constants and state types of the condenser fan speed controller
package fcs_pkg;
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned TENTH_NS = 100000000;
  localparam int unsigned TENTH_CYC = TENTH_NS / CLK_NS;
  localparam logic [3:0] SEC_TENTHS = 4'hA;
  localparam int unsigned HALF50_NS = 10000000;
  localparam int unsigned HALF60_NS = 8333333;
  localparam int unsigned HALF50_CYC = HALF50_NS / CLK_NS;
  localparam int unsigned HALF60_CYC = HALF60_NS / CLK_NS;
  localparam int unsigned FIRE_NS = 10000;
  localparam logic [9:0] FIRE_CYC = 10'(FIRE_NS / CLK_NS);
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [6:0] PCT_ZERO = 7'h00;
  localparam logic [7:0] MA_BASE = 8'h28;
  localparam logic [7:0] MA_SPAN = 8'hA0;
  localparam logic [1:0] FMODE_PROP = 2'h0;
  localparam logic [1:0] FMODE_ONOFF = 2'h1;
  localparam logic [1:0] FMODE_COMP = 2'h2;
  localparam logic [4:0] RF_FAN_C1 = 5'h03;
  localparam logic [4:0] RF_FAN_C2 = 5'h04;
  localparam logic [4:0] RF_S2_C1 = 5'h0C;
  localparam logic [4:0] RF_S3_C1 = 5'h0D;
  localparam logic [4:0] RF_S2_C2 = 5'h0E;
  localparam logic [4:0] RF_S3_C2 = 5'h0F;
  localparam int unsigned NRELAY = 4;
  typedef enum logic [3:0] {
    FCS_OFF = 4'h1,
    FCS_PICK = 4'h2,
    FCS_RUN = 4'h4,
    FCS_CUT = 4'h8
  } fcs_fan_st_t;
  typedef struct packed {
    fcs_fan_st_t st;
    logic defr_on;
    logic [7:0] pick;
    logic [7:0] byp;
    logic [6:0] lvl;
  } fcs_ch_t;
  typedef struct packed {
    fcs_ch_t [1:0] ch;
    logic [1:0][7:0] ana;
    logic [NRELAY-1:0] rly;
    logic alr;
  } fcs_top_t;
endpackage

// ---- hdl/fcs_tick.sv ----
// Tenth-second and one-second strobe generator
`timescale 1ns/1ns
module fcs_tick #(
  parameter int unsigned TENTH = fcs_pkg::TENTH_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Strobes
  fcs_tick_if.src tk
);
  typedef struct packed {
    logic [23:0] cnt;
    logic [3:0] ten;
    logic t;
    logic s;
  } fcs_tick_t;
  fcs_tick_t s_reg, s_next;
  localparam logic [23:0] LAST = 24'(TENTH - 1);

  always_comb begin
    s_next = s_reg;
    s_next.t = 1'b0;
    s_next.s = 1'b0;
    if (s_reg.cnt >= LAST) begin
      s_next.cnt = 24'h000000;
      s_next.t = 1'b1;
      if (s_reg.ten == fcs_pkg::SEC_TENTHS - 4'h1) begin
        s_next.ten = 4'h0;
        s_next.s = 1'b1;
      end else begin
        s_next.ten = s_reg.ten + 4'h1;
      end
    end else begin
      s_next.cnt = s_reg.cnt + 24'h000001;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign tk.tenth = s_reg.t;
  assign tk.sec = s_reg.s;
endmodule

// ---- hdl/fcs_tick_if.sv ----
// Timebase strobes passed from the tick generator to the controller
`timescale 1ns/1ns
interface fcs_tick_if;
  logic tenth;
  logic sec;
  modport src (output tenth, output sec);
  modport snk (input tenth, input sec);
endinterface

// ---- test/fcs_drive_stage.sv ----
// Fan drive stage model: mains zero-cross source and gate pulse counter
`timescale 1ns/1ns
module fcs_drive_stage #(
  parameter int HALF = 2000
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Drive side
  input wire logic fire_i,
  output logic zc_o,
  output int fires_o
);
  int cnt;
  logic fire_q;
  // Mains runs free, so crossings keep coming whether or not the fan runs
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 0;
      zc_o <= 1'b0;
      fire_q <= 1'b0;
      fires_o <= 0;
    end else begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      zc_o <= (cnt < HALF / 2);
      fire_q <= fire_i;
      if (fire_i && !fire_q) begin
        fires_o <= fires_o + 1;
      end
    end
  end
endmodule

// ---- test/tb.sv ----
// Self-checking bench for the condenser fan speed controller
`timescale 1ns/1ns
module tb;
  logic sys_clk_i = 0, rstn_i = 0, comp_run_a_i, comp_run_b_i, heat_mode_i, zero_cross_i, alarm_i;
  logic defrost_a_i = 0, defrost_b_i = 0, fan_follows_compressor_sel_i, combined_condenser_sel_i, mains_freq_sel_i;
  logic analog_out1_type_i, analog_out2_type_i, alarm_relay_pol_i, triac_fan_out_a_o, triac_fan_out_b_o, alarm_relay_o;
  logic [1:0] fan_output_mode_sel_i;
  logic [7:0] fan_pickup_interval_i, fan_cutoff_bypass_time_i, analog_fan_out_a_o, analog_fan_out_b_o;
  logic [6:0] cool_min_speed_i, cool_silent_max_speed_i, cool_high_speed_step_i, heat_min_speed_i;
  logic [6:0] heat_silent_max_speed_i, fan_step2_level_i, fan_step3_level_i, fan_level_a_o, fan_level_b_o;
  logic [15:0] cond_val_a_i, cond_val_b_i, cool_min_speed_setpoint_i, cool_prop_band_i, fan_cutoff_diff_i;
  logic [15:0] fan_cutoff_hyst_i, cool_high_speed_point_i, heat_min_speed_setpoint_i, heat_prop_band_i;
  logic [15:0] defrost_fan_thr_i = 0, defrost_fan_hyst_i = 0;
  logic [3:0][4:0] relay_func_i;
  logic [3:0] relay_pol_i, relay_out_o;
  logic [6:0] exp_q[$];
  logic sample_req = 0;
  int bad_count = 0, comparisons = 0, fires, f0, r;

  // Short timebase so pick-up and mains half-cycles fit a quick run
  fcs_fan_ctrl #(.TENTH_CYC(20), .HALF50_CYC(200), .HALF60_CYC(166)) i_fcs_fan_ctrl (.*);
  fcs_drive_stage #(.HALF(2000)) i_fcs_drive_stage (.sys_clk_i, .rstn_i, .fire_i(triac_fan_out_a_o),
    .zc_o(zero_cross_i), .fires_o(fires));

  always #5 sys_clk_i = ~sys_clk_i;

  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH %0t seen %0h want %0h", $time, seen, want);
    end
  endtask

  // Note the expected level; the monitor compares it at the next edge
  task automatic lvl(input logic [6:0] e, input int n);
    repeat (n) @(posedge sys_clk_i);
    exp_q.push_back(e);
    sample_req <= 1'b1;
    @(posedge sys_clk_i);
    sample_req <= 1'b0;
  endtask

  always @(posedge sys_clk_i) begin
    if (sample_req) begin
      chk({1'b0, fan_level_a_o}, {1'b0, exp_q.pop_front()});
    end
  end

  task automatic report_and_stop();
    $display("bad_count %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge sys_clk_i);
    bad_count++;
    report_and_stop();
  end

  initial begin
    {comp_run_a_i, comp_run_b_i, fan_follows_compressor_sel_i} = 3'h7;
    {heat_mode_i, alarm_i, combined_condenser_sel_i, mains_freq_sel_i} = 4'h0;
    {analog_out1_type_i, analog_out2_type_i, alarm_relay_pol_i, fan_output_mode_sel_i} = 5'h00;
    fan_pickup_interval_i = 8'h02;
    fan_cutoff_bypass_time_i = 8'h00;
    cool_min_speed_i = 7'h14;
    cool_silent_max_speed_i = 7'h50;
    cool_high_speed_step_i = 7'h5A;
    heat_min_speed_i = 7'h1E;
    heat_silent_max_speed_i = 7'h46;
    fan_step2_level_i = 7'h28;
    fan_step3_level_i = 7'h3C;
    {cond_val_a_i, cond_val_b_i, cool_min_speed_setpoint_i} = {16'h041A, 16'h041A, 16'h03E8};
    {cool_prop_band_i, heat_prop_band_i, fan_cutoff_diff_i} = {16'h0064, 16'h0064, 16'h01F4};
    {fan_cutoff_hyst_i, cool_high_speed_point_i, heat_min_speed_setpoint_i} = {16'h0032, 16'h07D0, 16'h01F4};
    relay_func_i = {5'h0D, 5'h00, 5'h0C, 5'h03};
    relay_pol_i = 4'h4;
    r = $urandom(63569);
    repeat (6) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    lvl(7'h64, 3); // pick-up
    lvl(7'h32, 80); // ramp
    cond_val_a_i <= 16'h0384;
    lvl(7'h14, 5); // below set point
    cond_val_a_i <= 16'h044C;
    lvl(7'h50, 5); // silent max
    cond_val_a_i <= 16'h07D0;
    lvl(7'h5A, 5); // high step
    fan_output_mode_sel_i <= 2'h1;
    cond_val_a_i <= 16'h041A;
    lvl(7'h64, 5); // on-off
    fan_output_mode_sel_i <= 2'h0;
    cond_val_a_i <= 16'h0190;
    lvl(7'h00, 5); // cut
    cond_val_a_i <= 16'h03B6;
    lvl(7'h64, 5); // restore
    lvl(7'h14, 80); // pick-up ends
    fan_output_mode_sel_i <= 2'h2;
    comp_run_a_i <= 1'b0;
    lvl(7'h00, 5); // no compressor
    comp_run_a_i <= 1'b1;
    lvl(7'h64, 80); // compressor runs
    fan_output_mode_sel_i <= 2'h0;
    fan_follows_compressor_sel_i <= 1'b0;
    comp_run_a_i <= 1'b0;
    lvl(7'h00, 5); // follows compressor
    comp_run_a_i <= 1'b1;
    r = $urandom % 100;
    cond_val_a_i <= 16'h0384;
    cond_val_b_i <= 16'(1000 + r);
    combined_condenser_sel_i <= 1'b1;
    lvl(7'(20 + 60 * r / 100), 80); // higher reading
    combined_condenser_sel_i <= 1'b0;
    cond_val_a_i <= 16'h041A;
    alarm_i <= 1'b1;
    alarm_relay_pol_i <= 1'b1;
    analog_out1_type_i <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    chk({4'h0, relay_out_o}, 8'h07); // relay codes
    chk({7'h00, alarm_relay_o}, 8'h00); // alarm polarity
    chk(analog_fan_out_a_o, 8'h78); // current loop
    chk(analog_fan_out_b_o, 8'h00); // phase-cut channel
    chk({1'b0, fan_level_b_o}, {1'b0, 7'(20 + 60 * r / 100)}); // own reading
    f0 = fires;
    repeat (4500) @(posedge sys_clk_i);
    chk(8'(fires - f0), 8'h00); // no gate pulses
    analog_out1_type_i <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      mains_freq_sel_i <= m[0];
      f0 = fires;
      repeat (4500) @(posedge sys_clk_i);
      chk({7'h00, fires > f0}, 8'h01); // phase cut
    end
    heat_mode_i <= 1'b1;
    cond_val_a_i <= 16'h0258;
    lvl(7'h1E, 80); // heating minimum
    cond_val_a_i <= 16'h01C2;
    lvl(7'h32, 5); // heating ramp
    defrost_fan_thr_i <= 16'h01F4;
    defrost_fan_hyst_i <= 16'h0032;
    defrost_a_i <= 1'b1;
    lvl(7'h00, 5); // below threshold
    cond_val_a_i <= 16'h0258;
    lvl(7'h64, 80); // full power
    report_and_stop();
  end
endmodule
